// ### fts_burst_seq.sv
// Burst address sequencer for the two low address bits
`timescale 1ns/10ps
module fts_burst_seq (
  // Burst state
  input  wire logic [1:0] start_low,
  input  wire logic [1:0] count,
  input  wire logic       interleaved,
  // Resulting low address
  output logic      [1:0] burst_low_address
);

  function automatic logic [1:0] step(input logic [1:0] s, input logic [1:0] c,
                                      input logic il);
    if (il)
      step = s ^ c;
    else
      step = 2'(s + c);
  endfunction

  always_comb
  begin
    burst_low_address = step(start_low, count, interleaved);
  end

endmodule

// ### fts_mem_model.sv
// Behavioural memory array that sits behind the access block
`timescale 1ns/10ps
module fts_mem_model #(
  parameter int ADDR_W = 21
) (
  // Clock
  input  wire logic              clk,
  // Read side, answered at once
  input  wire logic [ADDR_W-1:0] arr_addr,
  output logic      [31:0]       arr_rd_data,
  output logic      [3:0]        arr_rd_parity,
  // Write side, one pulse per write
  input  wire logic [ADDR_W-1:0] arr_wr_addr,
  input  wire logic [3:0]        arr_wr_lane,
  input  wire logic [31:0]       arr_wr_data,
  input  wire logic [3:0]        arr_wr_parity
);
  // Only sixteen words: the bench never needs more, and aliasing stays predictable
  logic [35:0] mem [16];
  initial
  begin
    for (int i = 0; i < 16; i++)
      mem[i] = {4'h0, {8{i[3:0]}}};
  end
  assign {arr_rd_parity, arr_rd_data} = mem[arr_addr[3:0]];
  always @(posedge clk)
  begin
    for (int l = 0; l < 4; l++)
      if (arr_wr_lane[l])
      begin
        mem[arr_wr_addr[3:0]][8*l +: 8] <= arr_wr_data[8*l +: 8];
        mem[arr_wr_addr[3:0]][32+l]     <= arr_wr_parity[l];
      end
  end
endmodule

// ### fts_pkg.sv
// Constants and types shared by the flow-through burst SRAM access logic
// Contract
// - Burst order select high steps low address bits as start XOR count.
// - Burst order select low steps low address bits by one, wrapping 11 to 00.
// - Qualified edge, chips enabled, load, write enable high starts read burst.
// - Advance during read burst reads next address, ignoring enables and write enable.
// - Read with output enable inactive advances address but keeps bus tri-stated.
// - Qualified edge, chips enabled, load, write enable low, some select low starts write.
// - Advance during write burst writes next address with selects of that cycle.
// - Write start with all byte selects high is an abort; nothing changes. Code still loads address and burst count and enters write op; array untouched.
// - Write continuation with all selects high advances address, stores nothing.
// - Clock qualify high makes the edge ignored; all state held. Code still shifts the sleep pipe and clears the write lane strobe.
// - Each low byte select writes its lane plus parity; other lanes keep contents.
// - Write enable low with all selects high writes no bytes.
// - Any write cycle tri-states data and parity regardless of output enable.
// - Output enable acts asynchronously and is masked during write cycles.
// - Read cycle tri-states bus when output enable inactive or deselected.
// - Read cycle with output enable active drives read data and parity.
// - After power-up the device is deselected with outputs tri-stated.
// - Sleep request stops operation within two cycles; sleep ignores inputs, tri-states bus.
// - Chip enable inactive on load edge deselects at once; advance keeps deselect.
// - Write data and selects are taken at the qualified edge after the address edge.
// - Advance increments counter regardless of enables; burst keeps its access type.
package fts_pkg;

  // Burst geometry
  localparam int BURST_W      = 2;
  localparam int LANE_BITS    = 8;
  localparam int DEF_ADDR_W   = 21;
  localparam int DEF_LANES    = 4;

  // Reset values
  localparam logic [1:0] CNT_RESET   = 2'h0;
  localparam logic [1:0] SLEEP_RESET = 2'h0;

  // Sleep timing, in clock periods, and the cycle counts derived from it
  localparam int SLEEP_ENTRY_TCYC    = 2;
  localparam int SLEEP_RECOVERY_TCYC = 2;
  localparam int CLK_PERIOD_NS       = 40;
  localparam int SLEEP_ENTRY_CYC     = (SLEEP_ENTRY_TCYC * CLK_PERIOD_NS) / CLK_PERIOD_NS;
  localparam int SLEEP_RECOVERY_CYC  = (SLEEP_RECOVERY_TCYC * CLK_PERIOD_NS) / CLK_PERIOD_NS;

  // Operation held for the current cycle
  typedef enum logic [1:0] {
    FTS_DESEL,
    FTS_READ,
    FTS_WRITE
  } fts_op_e;

endpackage

// ### fts_sram_access.sv
// Synchronous access control of a flow-through burst SRAM
`timescale 1ns/10ps
module fts_sram_access #(
  parameter int ADDR_W = fts_pkg::DEF_ADDR_W,
  parameter int LANES  = fts_pkg::DEF_LANES
) (
  // Clock and reset
  input  wire logic                                clk,
  input  wire logic                                rst_n,
  // Synchronous controls
  input  wire logic                                chip_enable_one_n,
  input  wire logic                                chip_enable_two,
  input  wire logic                                chip_enable_three_n,
  input  wire logic                                advance_load_n,
  input  wire logic                                write_enable_n,
  input  wire logic                                clock_qualify_n,
  input  wire logic                                burst_order_sel,
  input  wire logic                                sleep_request,
  input  wire logic [LANES-1:0]                    byte_write_sel_n,
  input  wire logic [ADDR_W-1:0]                   address,
  // Asynchronous output enable
  input  wire logic                                output_enable_n,
  // Common data bus
  input  wire logic [LANES*fts_pkg::LANE_BITS-1:0] dq_in,
  input  wire logic [LANES-1:0]                    parity_in,
  output logic      [LANES*fts_pkg::LANE_BITS-1:0] dq_out,
  output logic      [LANES-1:0]                    parity_out,
  output logic                                     dq_oe,
  // Memory array
  output logic      [ADDR_W-1:0]                   arr_addr,
  input  wire logic [LANES*fts_pkg::LANE_BITS-1:0] arr_rd_data,
  input  wire logic [LANES-1:0]                    arr_rd_parity,
  output logic      [ADDR_W-1:0]                   arr_wr_addr,
  output logic      [LANES-1:0]                    arr_wr_lane,
  output logic      [LANES*fts_pkg::LANE_BITS-1:0] arr_wr_data,
  output logic      [LANES-1:0]                    arr_wr_parity
);

  localparam int DW = LANES * fts_pkg::LANE_BITS;

  if (ADDR_W < fts_pkg::BURST_W + 1 || LANES < 1)
  begin : g_bad_param
    $error("fts_sram_access: ADDR_W must exceed 2 and LANES be at least 1");
  end

  // Sleep pipe is two flops deep; longer entry or exit times need a deeper pipe
  if (fts_pkg::SLEEP_ENTRY_CYC != 2 || fts_pkg::SLEEP_RECOVERY_CYC != 2)
  begin : g_bad_sleep
    $error("fts_sram_access: sleep entry and recovery must be two cycles");
  end

  typedef struct packed {
    fts_pkg::fts_op_e  op;
    logic [ADDR_W-1:0] addr;
    logic [1:0]        start_low;
    logic [1:0]        cnt;
    logic              pend;
    logic [ADDR_W-1:0] pend_addr;
    logic [ADDR_W-1:0] wr_addr;
    logic [LANES-1:0]  wr_lane;
    logic [DW-1:0]     wr_data;
    logic [LANES-1:0]  wr_parity;
    logic [1:0]        sleep_pipe;
  } fts_state_s;

  fts_state_s s;
  fts_state_s next_s;

  logic       sleeping;
  logic       qual;
  logic       chips_on;
  logic       all_sel_off;
  logic [1:0] step_cnt;
  logic [1:0] step_low;

  assign sleeping    = s.sleep_pipe[1];
  assign qual        = !clock_qualify_n && !sleeping;
  assign chips_on    = !chip_enable_one_n && chip_enable_two && !chip_enable_three_n;
  assign all_sel_off = &byte_write_sel_n;
  assign step_cnt    = 2'(s.cnt + 2'h1);

  fts_burst_seq u_seq (
    .start_low         (s.start_low),
    .count             (step_cnt),
    .interleaved       (burst_order_sel),
    .burst_low_address (step_low)
  );

  always_comb
  begin
    next_s            = s;
    next_s.sleep_pipe = {s.sleep_pipe[0], sleep_request};
    // Commit strobe is a single pulse so a stall never writes twice
    next_s.wr_lane    = '0;
    if (sleeping)
    begin
      // Pending work is dropped; the array keeps its contents
      next_s.op   = fts_pkg::FTS_DESEL;
      next_s.pend = 1'b0;
    end
    else if (qual)
    begin
      // Data phase of the previous write address
      if (s.pend)
      begin
        next_s.wr_addr   = s.pend_addr;
        next_s.wr_lane   = ~byte_write_sel_n;
        next_s.wr_data   = dq_in;
        next_s.wr_parity = parity_in;
      end
      next_s.pend = 1'b0;
      if (advance_load_n)
      begin
        // Continue burst; enables and write enable are ignored
        if (s.op != fts_pkg::FTS_DESEL)
        begin
          next_s.cnt = step_cnt;
          next_s.addr = {s.addr[ADDR_W-1:fts_pkg::BURST_W], step_low};
          next_s.pend = (s.op == fts_pkg::FTS_WRITE);
          next_s.pend_addr = {s.addr[ADDR_W-1:fts_pkg::BURST_W], step_low};
        end
      end
      else if (!chips_on)
      begin
        next_s.op = fts_pkg::FTS_DESEL;
      end
      else
      begin
        next_s.addr      = address;
        next_s.start_low = address[fts_pkg::BURST_W-1:0];
        next_s.cnt       = fts_pkg::CNT_RESET;
        next_s.pend_addr = address;
        if (write_enable_n)
        begin
          next_s.op = fts_pkg::FTS_READ;
        end
        else
        begin
          next_s.op   = fts_pkg::FTS_WRITE;
          next_s.pend = !all_sel_off;
        end
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s            <= '0;
      s.op         <= fts_pkg::FTS_DESEL;
      s.cnt        <= fts_pkg::CNT_RESET;
      s.sleep_pipe <= fts_pkg::SLEEP_RESET;
    end
    else
    begin
      s <= next_s;
    end
  end

  // Output enable is not sampled; it gates the drivers directly, so the
  // enable is not a flip-flop; neither are dq_out and parity_out, taken straight from the array.
  always_comb
  begin
    dq_oe = (s.op == fts_pkg::FTS_READ) && !output_enable_n && !sleeping;
  end

  // Flow-through: array data reaches the bus in the cycle after the edge
  assign dq_out        = arr_rd_data;
  assign parity_out    = arr_rd_parity;
  assign arr_addr      = s.addr;
  assign arr_wr_addr   = s.wr_addr;
  assign arr_wr_lane   = s.wr_lane;
  assign arr_wr_data   = s.wr_data;
  assign arr_wr_parity = s.wr_parity;

  a_read_start_addr : assert property (@(posedge clk) disable iff (!rst_n)
    (qual && !advance_load_n && chips_on && write_enable_n)
    |=> (s.op == fts_pkg::FTS_READ) && (arr_addr == $past(address)))
    else $error("read start did not load the external address");

  a_write_start_op : assert property (@(posedge clk) disable iff (!rst_n)
    (qual && !advance_load_n && chips_on && !write_enable_n && !all_sel_off)
    |=> (s.op == fts_pkg::FTS_WRITE) && s.pend && (arr_addr == $past(address)))
    else $error("write start did not arm a pending write");

  a_abort_no_write : assert property (@(posedge clk) disable iff (!rst_n)
    (qual && !advance_load_n && chips_on && !write_enable_n && all_sel_off)
    |=> !s.pend ##1 (arr_wr_lane == '0))
    else $error("aborted write start changed memory");

  a_interleave_step : assert property (@(posedge clk) disable iff (!rst_n)
    (qual && advance_load_n && s.op != fts_pkg::FTS_DESEL && burst_order_sel)
    |=> arr_addr[1:0] == ($past(s.start_low) ^ $past(step_cnt)))
    else $error("interleaved burst step wrong");

  a_linear_step : assert property (@(posedge clk) disable iff (!rst_n)
    (qual && advance_load_n && s.op != fts_pkg::FTS_DESEL && !burst_order_sel)
    |=> arr_addr[1:0] == 2'($past(arr_addr[1:0]) + 2'h1))
    else $error("linear burst step wrong");

  a_stall_hold : assert property (@(posedge clk) disable iff (!rst_n)
    (clock_qualify_n && !sleeping && !s.sleep_pipe[0])
    |=> $stable(arr_addr) && $stable(s.op) && (arr_wr_lane == '0))
    else $error("stalled edge changed state");

  a_write_commit : assert property (@(posedge clk) disable iff (!rst_n)
    (qual && s.pend)
    |=> (arr_wr_lane == ~$past(byte_write_sel_n)) && (arr_wr_addr == $past(s.pend_addr))
        && (arr_wr_data == $past(dq_in)))
    else $error("write data phase not committed");

  a_write_tristate : assert property (@(posedge clk) disable iff (!rst_n)
    (s.op == fts_pkg::FTS_WRITE) |-> !dq_oe)
    else $error("bus driven during write");

  a_read_drive : assert property (@(posedge clk) disable iff (!rst_n)
    (s.op == fts_pkg::FTS_READ && !sleeping && !output_enable_n) |-> dq_oe)
    else $error("read with output enable not driven");

  a_desel_now : assert property (@(posedge clk) disable iff (!rst_n)
    (qual && !advance_load_n && !chips_on)
    |=> (s.op == fts_pkg::FTS_DESEL) && !dq_oe)
    else $error("deselect not taken at once");

  a_sleep_entry : assert property (@(posedge clk) disable iff (!rst_n)
    sleep_request ##1 sleep_request |=> sleeping ##1 (s.op == fts_pkg::FTS_DESEL) && !dq_oe)
    else $error("sleep not entered within two cycles");

  a_desel_stays : assert property (@(posedge clk) disable iff (!rst_n)
    (qual && advance_load_n && s.op == fts_pkg::FTS_DESEL)
    |=> (s.op == fts_pkg::FTS_DESEL) && $stable(arr_addr))
    else $error("advance while deselected changed state");

  a_desel_no_pend : assert property (@(posedge clk) disable iff (!rst_n)
    (qual && !advance_load_n && !chips_on)
    |=> $stable(arr_addr) && !s.pend)
    else $error("deselect changed address or armed a write");

  a_read_continue : assert property (@(posedge clk) disable iff (!rst_n)
    (qual && advance_load_n && s.op == fts_pkg::FTS_READ)
    |=> (s.op == fts_pkg::FTS_READ) && (s.cnt == $past(step_cnt)))
    else $error("read burst did not continue");

  a_write_continue : assert property (@(posedge clk) disable iff (!rst_n)
    (qual && advance_load_n && s.op == fts_pkg::FTS_WRITE)
    |=> (s.op == fts_pkg::FTS_WRITE) && s.pend && (s.pend_addr == arr_addr))
    else $error("write burst did not arm next address");

  a_upper_addr_kept : assert property (@(posedge clk) disable iff (!rst_n)
    (qual && advance_load_n && s.op != fts_pkg::FTS_DESEL)
    |=> arr_addr[ADDR_W-1:2] == $past(arr_addr[ADDR_W-1:2]))
    else $error("burst left its four-word group");

  a_wrap_four : assert property (@(posedge clk) disable iff (!rst_n)
    (qual && advance_load_n && s.op != fts_pkg::FTS_DESEL && s.cnt == 2'h3)
    |=> arr_addr[1:0] == $past(s.start_low))
    else $error("burst did not wrap to its start");

  a_burst_start_cnt : assert property (@(posedge clk) disable iff (!rst_n)
    (qual && !advance_load_n && chips_on)
    |=> (s.cnt == fts_pkg::CNT_RESET) && (s.start_low == $past(address[1:0])))
    else $error("burst start did not reset the counter");

  a_pend_only_write : assert property (@(posedge clk) disable iff (!rst_n)
    s.pend |-> (s.op == fts_pkg::FTS_WRITE))
    else $error("pending write outside a write burst");

  a_dummy_advance : assert property (@(posedge clk) disable iff (!rst_n)
    (qual && advance_load_n && s.op == fts_pkg::FTS_READ && output_enable_n)
    |=> arr_addr[1:0] == $past(step_low))
    else $error("dummy read did not advance");

  a_read_no_pend : assert property (@(posedge clk) disable iff (!rst_n)
    (qual && !advance_load_n && chips_on && write_enable_n)
    |=> !s.pend)
    else $error("read start armed a write");

  a_abort_tristate : assert property (@(posedge clk) disable iff (!rst_n)
    (qual && !advance_load_n && chips_on && !write_enable_n && all_sel_off)
    |=> (s.op == fts_pkg::FTS_WRITE) && !dq_oe)
    else $error("aborted write drove the bus");

  a_write_pend_addr : assert property (@(posedge clk) disable iff (!rst_n)
    (qual && !advance_load_n && chips_on && !write_enable_n)
    |=> s.pend_addr == $past(address))
    else $error("write address not kept for data phase");

  a_write_parity : assert property (@(posedge clk) disable iff (!rst_n)
    (qual && s.pend)
    |=> arr_wr_parity == $past(parity_in))
    else $error("write parity not taken with data");

  a_sel_off_no_write : assert property (@(posedge clk) disable iff (!rst_n)
    (qual && s.pend && all_sel_off)
    |=> arr_wr_lane == '0)
    else $error("write with all selects high stored bytes");

  a_no_commit_idle : assert property (@(posedge clk) disable iff (!rst_n)
    !(qual && s.pend)
    |=> (arr_wr_lane == '0) && $stable(arr_wr_data))
    else $error("array written without a data phase");

  a_stall_hold_wr : assert property (@(posedge clk) disable iff (!rst_n)
    (clock_qualify_n && !sleeping && !s.sleep_pipe[0])
    |=> $stable(s.cnt) && $stable(s.pend) && $stable(arr_wr_addr) && $stable(s.start_low))
    else $error("stalled edge changed burst state");

  a_oe_mask : assert property (@(posedge clk) disable iff (!rst_n)
    output_enable_n |-> !dq_oe)
    else $error("bus driven with output enable inactive");

  a_desel_tristate : assert property (@(posedge clk) disable iff (!rst_n)
    (s.op == fts_pkg::FTS_DESEL) |-> !dq_oe)
    else $error("bus driven while deselected");

  a_sleep_tristate : assert property (@(posedge clk) disable iff (!rst_n)
    sleeping |-> !dq_oe)
    else $error("bus driven while sleeping");

  a_sleep_no_commit : assert property (@(posedge clk) disable iff (!rst_n)
    sleeping
    |=> (arr_wr_lane == '0) && !s.pend && $stable(arr_addr))
    else $error("sleeping device changed the array or address");

  a_sleep_sampled : assert property (@(posedge clk) disable iff (!rst_n)
    sleep_request
    |=> s.sleep_pipe[0])
    else $error("sleep request not sampled");

  a_sleep_exit : assert property (@(posedge clk) disable iff (!rst_n)
    !sleep_request ##1 !sleep_request
    |=> !sleeping)
    else $error("sleep not left within two cycles");

endmodule

// ### tb_top.sv
// Self-checking bench for the flow-through SRAM access block
`timescale 1ns/10ps
module tb_top;
  localparam logic [2:0] EN  = 3'h2;
  localparam logic [2:0] OFF = 3'h0;
  logic        clk = 1'h0, rst_n = 1'h0, adv_n = 1'h0, we_n = 1'h1, oe_n = 1'h0;
  logic        cq_n = 1'h0, mode = 1'h1, zz = 1'h0, oe;
  logic [2:0]  ce = 3'h0;
  logic [3:0]  sel = 4'hf, pin = 4'h0, prd, pwp, lane, par;
  logic [20:0] addr = 21'h0, aa, wa;
  logic [31:0] din = 32'h0, rd, wd, dq;
  int          n_fail = 0, num_checks = 0, cyc = 0;

  fts_sram_access i_dut (
    .clk(clk), .rst_n(rst_n), .chip_enable_one_n(ce[2]), .chip_enable_two(ce[1]),
    .chip_enable_three_n(ce[0]), .advance_load_n(adv_n), .write_enable_n(we_n),
    .clock_qualify_n(cq_n), .burst_order_sel(mode), .sleep_request(zz),
    .byte_write_sel_n(sel), .address(addr), .output_enable_n(oe_n), .dq_in(din),
    .parity_in(pin), .dq_out(dq), .parity_out(par), .dq_oe(oe), .arr_addr(aa),
    .arr_rd_data(rd), .arr_rd_parity(prd), .arr_wr_addr(wa), .arr_wr_lane(lane),
    .arr_wr_data(wd), .arr_wr_parity(pwp));
  fts_mem_model i_mem (
    .clk(clk), .arr_addr(aa), .arr_rd_data(rd), .arr_rd_parity(prd),
    .arr_wr_addr(wa), .arr_wr_lane(lane), .arr_wr_data(wd), .arr_wr_parity(pwp));

  always #20 clk = ~clk;
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 400)
    begin
      n_fail++;
      end_sim();
    end
  end

  task automatic end_sim();
    if (n_fail == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Inputs change at the falling edge; outputs are judged one falling edge later
  task automatic step(input logic [2:0] c, input logic a, input logic w,
                      input logic [3:0] s, input logic [20:0] ad);
    ce = c;
    adv_n = a;
    we_n = w;
    sel = s;
    addr = ad;
    @(negedge clk);
  endtask

  task automatic t_burst(input logic m, input logic [7:0] seq);
    mode = m;
    step(EN, 1'h0, 1'h1, 4'hf, 21'h1);
    chk(aa, 21'h1);
    chk({oe, dq}, {1'h1, 32'h11111111});
    for (int k = 0; k < 4; k++)
    begin
      step(OFF, 1'h1, 1'h0, 4'hf, 21'h0);
      chk(aa[1:0], seq[2*k +: 2]);
    end
    chk(oe, 1'h1);
  endtask
  task automatic t_write();
    step(EN, 1'h0, 1'h0, 4'ha, 21'h5);
    chk(oe, 1'h0);
    din = 32'hddccbbaa;
    pin = 4'hf;
    step(OFF, 1'h0, 1'h1, 4'ha, 21'h0);
    chk({wa, lane}, {21'h5, 4'h5});
    step(EN, 1'h0, 1'h1, 4'hf, 21'h5);
    chk({par, dq}, {4'h5, 32'h55cc55aa});
  endtask
  task automatic t_abort();
    mode = 1'h0;
    step(EN, 1'h0, 1'h0, 4'hf, 21'h6);
    chk(oe, 1'h0);
    step(OFF, 1'h0, 1'h1, 4'h0, 21'h0);
    chk(lane, 4'h0);
    step(EN, 1'h0, 1'h0, 4'h0, 21'h7);
    step(OFF, 1'h1, 1'h1, 4'hf, 21'h0);
    chk({aa, lane}, {21'h4, 4'h0});
    step(OFF, 1'h0, 1'h1, 4'h0, 21'h0);
    chk({wa, lane}, {21'h4, 4'hf});
  endtask
  task automatic t_stall();
    step(EN, 1'h0, 1'h1, 4'hf, 21'h8);
    cq_n = 1'h1;
    step(EN, 1'h0, 1'h0, 4'h0, 21'h3);
    chk({aa, lane}, {21'h8, 4'h0});
    cq_n = 1'h0;
    step(OFF, 1'h1, 1'h1, 4'hf, 21'h0);
    chk(aa, 21'h9);
  endtask
  task automatic t_dummy();
    oe_n = 1'h1;
    step(EN, 1'h0, 1'h1, 4'hf, 21'h2);
    chk({aa, oe}, {21'h2, 1'h0});
    step(OFF, 1'h1, 1'h1, 4'hf, 21'h0);
    chk({aa, oe}, {21'h3, 1'h0});
    #1 oe_n = 1'h0;
    #1 chk(oe, 1'h1);
    step(OFF, 1'h0, 1'h1, 4'hf, 21'h2);
    chk(oe, 1'h0);
    step(EN, 1'h1, 1'h1, 4'hf, 21'h0);
    chk(oe, 1'h0);
  endtask
  task automatic t_sleep();
    zz = 1'h1;
    step(OFF, 1'h0, 1'h1, 4'hf, 21'h0);
    step(OFF, 1'h0, 1'h1, 4'hf, 21'h0);
    step(EN, 1'h0, 1'h1, 4'hf, 21'h1);
    chk(oe, 1'h0);
    zz = 1'h0;
    step(OFF, 1'h0, 1'h1, 4'hf, 21'h0);
    step(OFF, 1'h0, 1'h1, 4'hf, 21'h0);
    step(EN, 1'h0, 1'h1, 4'hf, 21'h1);
    chk({aa, oe}, {21'h1, 1'h1});
  endtask

  initial
  begin
    repeat (12) @(negedge clk);
    rst_n = 1'h1;
    chk(oe, 1'h0);
    t_burst(1'h1, 8'h6c);
    t_burst(1'h0, 8'h4e);
    t_write();
    t_abort();
    t_stall();
    t_dummy();
    t_sleep();
    end_sim();
  end
endmodule
